// ==== hdl/ddrcs_pkg.sv ====
// Purpose: Shared constants for the DDR command scheduler.
// Assumes: Core clock of 40 MHz; refresh timebase clock of 200 ns.
// Notes:   Cycle counts derive from times in ns.
package ddrcs_pkg;
   localparam int CLK_NS         = 25;
   localparam int REF_CLK_NS     = 200;
   localparam int WORD_W         = 36;
   localparam int CODE_LSB       = 32;
   localparam int CODE_W         = 3;
   localparam int MAX_COL_W      = 13;
   localparam int MAX_ROW_W      = 15;
   localparam int MAX_BANK_W     = 2;
   localparam int FIFO_DEPTH     = 16;
   localparam int AUTO_CLOSE_BIT = 10;
   localparam int WAIT_W         = 16;
   localparam int PIPE_W         = 16;

   // Mode word layout
   localparam int BL_LSB  = 0;
   localparam int BT_BIT  = 3;
   localparam int CAS_LSB = 4;
   localparam logic [2:0] BL2_CODE   = 3'h1;
   localparam logic [2:0] BL4_CODE   = 3'h2;
   localparam logic [2:0] BL8_CODE   = 3'h3;
   localparam logic [2:0] CAS20_CODE = 3'h2;
   localparam logic [2:0] CAS25_CODE = 3'h6;
   localparam logic [2:0] CAS30_CODE = 3'h3;

   // User command codes
   localparam logic [2:0] UCMD_READ  = 3'h5;
   localparam logic [2:0] UCMD_WRITE = 3'h4;
   localparam logic [2:0] UCMD_REF   = 3'h1;
   localparam logic [2:0] UCMD_PRE   = 3'h2;

   // Memory command codes {ras_n, cas_n, we_n}
   localparam logic [2:0] MEM_NOP   = 3'h7;
   localparam logic [2:0] MEM_ACT   = 3'h3;
   localparam logic [2:0] MEM_READ  = 3'h5;
   localparam logic [2:0] MEM_WRITE = 3'h4;
   localparam logic [2:0] MEM_PRE   = 3'h2;
   localparam logic [2:0] MEM_REF   = 3'h1;
   localparam logic [2:0] MEM_MRS   = 3'h0;

   localparam int T_RP_NS   = 20;
   localparam int T_RCD_NS  = 20;
   localparam int T_RFC_NS  = 120;
   localparam int T_MRD_NS  = 15;
   localparam int T_WR_NS   = 15;
   localparam int T_INIT_NS = 200000;
   localparam int T_REFI_NS = 7800;

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam int T_RP_CYC   = cyc_up(T_RP_NS);
   localparam int T_RCD_CYC  = cyc_up(T_RCD_NS);
   localparam int T_RFC_CYC  = cyc_up(T_RFC_NS);
   localparam int T_MRD_CYC  = cyc_up(T_MRD_NS);
   localparam int T_WR_CYC   = cyc_up(T_WR_NS);
   localparam int INIT_CYC   = cyc_up(T_INIT_NS);
   localparam int REFI_TICKS = T_REFI_NS / REF_CLK_NS;

   typedef enum {
      ST_POWERUP, ST_INIT_MRS, ST_IDLE, ST_DECODE, ST_PRE, ST_ACT,
      ST_RW, ST_BURST, ST_REF_PRE, ST_REF
   } ddrcs_state_t;
endpackage : ddrcs_pkg

// ==== hdl/ddrcs_fifo_if.sv ====
// Purpose: Valid/ready carrier between queue and scheduler.
// Assumes: Single clock.
// Notes:   Transfer when valid and ready are both high.
`timescale 1ns/100ps
interface ddrcs_fifo_if #(parameter int WIDTH = 36);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ddrcs_fifo_if

// ==== hdl/ddrcs_fifo.sv ====
// Purpose: Command/address queue in front of the scheduler.
// Assumes: DEPTH is a power of two.
// Notes:   First-word-fall-through; data read straight from the array.
`timescale 1ns/100ps
module ddrcs_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
)(
   input  wire logic             mclk_in,
   input  wire logic             reset_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   ddrcs_fifo_if.src             fifo_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign push  = in_valid_in && !full;
   assign pop   = fifo_out.valid && fifo_out.ready;

   assign in_ready_out   = !full;
   assign fifo_out.valid = !empty;
   assign fifo_out.data  = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : ddrcs_fifo

// ==== hdl/ddrcs_scheduler.sv ====
// Purpose: Command and address scheduler of a DDR SDRAM controller.
// Assumes: One open row at a time; refresh timebase on refresh_clk_in.
// Notes:   Unknown user codes are dropped.
//
// Notes on behaviour
// - Each command comes from one 36-bit word.
// - Bit 35 of the word is ignored.
// - Codes 101 read, 100 write, 010 precharge.
// - Code 001 requests a refresh.
// - Burst length 2, 4 or 8, fixed.
// - Burst length and type go in bits 0-3.
// - CAS latency in bits 4-6; 2, 2.5, 3.
// - Read capture enable timed by CAS latency.
// - Registered DIMM adds one clock to data.
// - Precharge before other row; skip same row.
// - Row change from row, bank, chip compare.
// - Column bit 10 never requests auto close.
// - Periodic auto refresh on its own.
// - Refresh waits for current burst end.
// - Row field starts just above column field.
// - Widths, type, timing are compile-time parameters.
// - Up to 13 column, 15 row, 2 bank bits.
`timescale 1ns/100ps
module ddrcs_scheduler
   import ddrcs_pkg::*;
#(
   parameter int BURST_LEN   = 8,
   parameter int BURST_TYPE  = 0,
   parameter int CAS_HALF    = 5,
   parameter int REG_DIMM    = 0,
   parameter int COL_W       = 10,
   parameter int ROW_W       = 13,
   parameter int BANK_W      = 2,
   parameter int CHIP_W      = 1,
   parameter int INIT_CYCLES = INIT_CYC,
   parameter int REFI_COUNT  = REFI_TICKS
)(
   input  wire logic                  mclk_in,
   input  wire logic                  reset_in,
   input  wire logic [WORD_W-1:0]     user_cmd_addr_word_in,
   input  wire logic                  user_valid_in,
   output logic                       user_ready_out,
   input  wire logic                  refresh_clk_in,
   output logic                       cke_out,
   output logic [(1<<CHIP_W)-1:0]     cs_n_out,
   output logic                       ras_n_out,
   output logic                       cas_n_out,
   output logic                       we_n_out,
   output logic [BANK_W-1:0]          ba_out,
   output logic [MAX_ROW_W-1:0]       addr_out,
   output logic                       read_en_out,
   output logic                       write_en_out,
   output logic                       init_done_out
);
   localparam int CS_N   = 1 << CHIP_W;
   localparam int BC     = BURST_LEN / 2;
   localparam int RD_LAT = (CAS_HALF + 1) / 2 + REG_DIMM;
   localparam int WR_LAT = 1 + REG_DIMM;

   ddrcs_fifo_if #(.WIDTH(WORD_W)) q_if ();

   ddrcs_state_t              state_reg, state_next;
   logic [WAIT_W-1:0]         wait_reg, wait_next, refi_reg;
   logic [WORD_W-1:0]         cur_reg;
   logic [2:0]                cmd_reg, cmd_next;
   logic [CS_N-1:0]           cs_n_reg, cs_n_next;
   logic [BANK_W-1:0]         ba_reg, ba_next;
   logic [MAX_ROW_W-1:0]      addr_reg, addr_next;
   logic [MAX_ROW_W-1:0]      cur_row, cur_bank, cur_chip;
   logic [MAX_ROW_W-1:0]      open_row_reg, open_bank_reg, open_chip_reg;
   logic [MAX_ROW_W-1:0]      mode_word;
   logic                      open_valid_reg, open_set, open_clear;
   logic                      same_row, cur_rw, pop;
   logic                      ref_pend_reg, ref_done, user_ref_set;
   logic                      refi_wrap, init_done_reg;
   logic                      rclk_meta_reg, rclk_sync_reg, rclk_prev_reg;
   logic                      rd_start, wr_start, rd_en_reg, wr_en_reg;
   logic [PIPE_W-1:0]         rd_pipe_reg, wr_pipe_reg;

   // fields up to 15 bits
   // Pick a field of the word, zero-extended
   function automatic logic [MAX_ROW_W-1:0] field(
      input logic [WORD_W-1:0] w, input int lsb, input int width);
      logic [MAX_ROW_W-1:0] f;
      f = '0;
      for (int i = 0; i < width; i++) begin
         f[i] = w[lsb + i];
      end
      return f;
   endfunction : field

   // Column onto pins, stepping over the auto close bit
   function automatic logic [MAX_ROW_W-1:0] col_pins(
      input logic [WORD_W-1:0] w);
      logic [MAX_ROW_W-1:0] a;
      a = '0;
      for (int i = 0; i < COL_W; i++) begin
         if (i < AUTO_CLOSE_BIT) begin
            a[i] = w[i];
         end else begin
            a[i + 1] = w[i];
         end
      end
      return a;
   endfunction : col_pins

   function automatic logic [CS_N-1:0] cs_of(
      input logic [MAX_ROW_W-1:0] chip);
      logic [CS_N-1:0] c;
      c = '1;
      c[chip[CHIP_W-1:0]] = 1'b0;
      return c;
   endfunction : cs_of

   ddrcs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_in      (mclk_in),
      .reset_in     (reset_in),
      .in_valid_in  (user_valid_in),
      .in_data_in   (user_cmd_addr_word_in),
      .in_ready_out (user_ready_out),
      .fifo_out     (q_if.src)
   );

   assign cur_row  = field(cur_reg, COL_W, ROW_W);
   assign cur_bank = field(cur_reg, COL_W + ROW_W, BANK_W);
   assign cur_chip = field(cur_reg, COL_W + ROW_W + BANK_W, CHIP_W);
   assign same_row = (cur_row == open_row_reg) &&
                     (cur_bank == open_bank_reg) &&
                     (cur_chip == open_chip_reg);
   assign cur_rw = (cur_reg[CODE_LSB +: CODE_W] == UCMD_READ) ||
                   (cur_reg[CODE_LSB +: CODE_W] == UCMD_WRITE);
   assign q_if.ready = pop;

   always_comb begin
      mode_word = '0;
      mode_word[BT_BIT] = (BURST_TYPE != 0);
      case (BURST_LEN)
         2: mode_word[BL_LSB +: 3] = BL2_CODE;
         4: mode_word[BL_LSB +: 3] = BL4_CODE;
         default: mode_word[BL_LSB +: 3] = BL8_CODE;
      endcase
      case (CAS_HALF)
         4: mode_word[CAS_LSB +: 3] = CAS20_CODE;
         6: mode_word[CAS_LSB +: 3] = CAS30_CODE;
         default: mode_word[CAS_LSB +: 3] = CAS25_CODE;
      endcase
   end

   always_comb begin
      state_next   = state_reg;
      wait_next    = (wait_reg == '0) ? '0 : wait_reg - 1'b1;
      cmd_next     = MEM_NOP;
      cs_n_next    = '1;
      ba_next      = cur_bank[BANK_W-1:0];
      addr_next    = '0;
      pop          = 1'b0;
      open_set     = 1'b0;
      open_clear   = 1'b0;
      ref_done     = 1'b0;
      user_ref_set = 1'b0;
      rd_start     = 1'b0;
      wr_start     = 1'b0;
      case (state_reg)
         ST_POWERUP: begin
            if (wait_reg == '0) begin
               cmd_next  = MEM_PRE;
               cs_n_next = '0;
               addr_next[AUTO_CLOSE_BIT] = 1'b1;
               wait_next = WAIT_W'(T_RP_CYC - 1);
               state_next = ST_INIT_MRS;
            end
         end
         ST_INIT_MRS: begin
            if (wait_reg == '0) begin
               cmd_next   = MEM_MRS;
               cs_n_next  = '0;
               ba_next    = '0;
               addr_next  = mode_word;
               wait_next  = WAIT_W'(T_MRD_CYC - 1);
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (wait_reg != '0) begin
               state_next = ST_IDLE;
            end else if (ref_pend_reg) begin
               state_next = ST_REF_PRE;
            end else if (q_if.valid) begin
               pop        = 1'b1;
               state_next = ST_DECODE;
            end
         end
         ST_DECODE: begin
            case (cur_reg[CODE_LSB +: CODE_W])
               UCMD_READ, UCMD_WRITE: begin
                  if (open_valid_reg && same_row) begin
                     state_next = ST_RW;
                  end else if (open_valid_reg) begin
                     state_next = ST_PRE;
                  end else begin
                     state_next = ST_ACT;
                  end
               end
               UCMD_REF: begin
                  user_ref_set = 1'b1;
                  state_next   = ST_IDLE;
               end
               UCMD_PRE: state_next = ST_PRE;
               default: state_next = ST_IDLE;
            endcase
         end
         ST_PRE: begin
            if (wait_reg == '0) begin
               cmd_next   = MEM_PRE;
               cs_n_next  = '0;
               addr_next[AUTO_CLOSE_BIT] = 1'b1;
               open_clear = 1'b1;
               wait_next  = WAIT_W'(T_RP_CYC - 1);
               state_next = cur_rw ? ST_ACT : ST_IDLE;
            end
         end
         ST_ACT: begin
            if (wait_reg == '0) begin
               cmd_next   = MEM_ACT;
               cs_n_next  = cs_of(cur_chip);
               addr_next  = cur_row;
               open_set   = 1'b1;
               wait_next  = WAIT_W'(T_RCD_CYC - 1);
               state_next = ST_RW;
            end
         end
         ST_RW: begin
            if (wait_reg == '0) begin
               addr_next = col_pins(cur_reg);
               cs_n_next = cs_of(cur_chip);
               if (cur_reg[CODE_LSB +: CODE_W] == UCMD_READ) begin
                  cmd_next  = MEM_READ;
                  rd_start  = 1'b1;
                  wait_next = WAIT_W'(BC - 1);
               end else begin
                  cmd_next  = MEM_WRITE;
                  wr_start  = 1'b1;
                  wait_next = WAIT_W'(BC + WR_LAT + T_WR_CYC - 1);
               end
               state_next = ST_BURST;
            end
         end
         ST_BURST: begin
            if (wait_reg == '0) begin
               state_next = ST_IDLE;
            end
         end
         ST_REF_PRE: begin
            if (wait_reg == '0) begin
               if (open_valid_reg) begin
                  cmd_next   = MEM_PRE;
                  cs_n_next  = '0;
                  addr_next[AUTO_CLOSE_BIT] = 1'b1;
                  open_clear = 1'b1;
                  wait_next  = WAIT_W'(T_RP_CYC - 1);
               end
               state_next = ST_REF;
            end
         end
         ST_REF: begin
            if (wait_reg == '0) begin
               cmd_next   = MEM_REF;
               cs_n_next  = '0;
               ref_done   = 1'b1;
               wait_next  = WAIT_W'(T_RFC_CYC - 1);
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= ST_POWERUP;
         wait_reg  <= WAIT_W'(INIT_CYCLES - 1);
      end else begin
         state_reg <= state_next;
         wait_reg  <= wait_next;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cur_reg <= '0;
      end else if (pop) begin
         cur_reg <= q_if.data;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cmd_reg  <= MEM_NOP;
         cs_n_reg <= '1;
         ba_reg   <= '0;
         addr_reg <= '0;
      end else begin
         cmd_reg  <= cmd_next;
         cs_n_reg <= cs_n_next;
         ba_reg   <= ba_next;
         addr_reg <= addr_next;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         open_valid_reg <= 1'b0;
         open_row_reg   <= '0;
         open_bank_reg  <= '0;
         open_chip_reg  <= '0;
      end else if (open_set) begin
         open_valid_reg <= 1'b1;
         open_row_reg   <= cur_row;
         open_bank_reg  <= cur_bank;
         open_chip_reg  <= cur_chip;
      end else if (open_clear) begin
         open_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         init_done_reg <= 1'b0;
      end else if (state_reg == ST_INIT_MRS && wait_reg == '0) begin
         init_done_reg <= 1'b1;
      end
   end

   // Refresh timebase synchroniser
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rclk_meta_reg <= 1'b0;
         rclk_sync_reg <= 1'b0;
         rclk_prev_reg <= 1'b0;
      end else begin
         rclk_meta_reg <= refresh_clk_in;
         rclk_sync_reg <= rclk_meta_reg;
         rclk_prev_reg <= rclk_sync_reg;
      end
   end

   assign refi_wrap = rclk_sync_reg && !rclk_prev_reg &&
                      (refi_reg == WAIT_W'(REFI_COUNT - 1));
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         refi_reg <= '0;
      end else if (rclk_sync_reg && !rclk_prev_reg) begin
         refi_reg <= refi_wrap ? '0 : refi_reg + 1'b1;
      end
   end

   // Set wins over clear
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         ref_pend_reg <= 1'b0;
      end else if (refi_wrap || user_ref_set) begin
         ref_pend_reg <= 1'b1;
      end else if (ref_done) begin
         ref_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_pipe_reg <= '0;
         wr_pipe_reg <= '0;
         rd_en_reg   <= 1'b0;
         wr_en_reg   <= 1'b0;
      end else begin
         rd_pipe_reg <= {rd_pipe_reg[PIPE_W-2:0], rd_start};
         wr_pipe_reg <= {wr_pipe_reg[PIPE_W-2:0], wr_start};
         rd_en_reg   <= |rd_pipe_reg[RD_LAT-1 +: BC];
         wr_en_reg   <= |wr_pipe_reg[WR_LAT-1 +: BC];
      end
   end

   assign cke_out       = init_done_reg || state_reg != ST_POWERUP;
   assign cs_n_out      = cs_n_reg;
   assign ras_n_out     = cmd_reg[2];
   assign cas_n_out     = cmd_reg[1];
   assign we_n_out      = cmd_reg[0];
   assign ba_out        = ba_reg;
   assign addr_out      = addr_reg;
   assign read_en_out   = rd_en_reg;
   assign write_en_out  = wr_en_reg;
   assign init_done_out = init_done_reg;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   pop_when_idle_a: assert property (
      pop |-> state_reg == ST_IDLE && !ref_pend_reg && q_if.valid)
      else $error("word taken while busy");
   no_auto_close_a: assert property (
      (cmd_reg == MEM_READ || cmd_reg == MEM_WRITE)
      |-> !addr_reg[AUTO_CLOSE_BIT])
      else $error("auto close bit set on access");
   same_row_skip_a: assert property (
      state_reg == ST_DECODE && cur_rw && open_valid_reg && same_row
      |=> state_reg == ST_RW)
      else $error("same row access not direct");
   row_change_pre_a: assert property (
      state_reg == ST_DECODE && cur_rw && open_valid_reg && !same_row
      |=> state_reg == ST_PRE)
      else $error("row change without precharge");
   read_latency_a: assert property (
      cmd_reg == MEM_READ |-> !read_en_out ##RD_LAT read_en_out)
      else $error("read enable misplaced");
   write_latency_a: assert property (
      cmd_reg == MEM_WRITE |-> ##WR_LAT write_en_out)
      else $error("write enable misplaced");
   ref_after_burst_a: assert property (
      state_reg == ST_BURST |-> cmd_reg != MEM_REF && !ref_done)
      else $error("refresh inside burst");
   periodic_ref_a: assert property (
      refi_wrap && init_done_reg |-> ##[1:64] cmd_reg == MEM_REF)
      else $error("periodic refresh missing");
   mode_word_a: assert property (
      cmd_reg == MEM_MRS |-> addr_reg == mode_word && ba_reg == '0)
      else $error("mode word wrong");
   user_ref_a: assert property (
      user_ref_set |=> ref_pend_reg)
      else $error("user refresh lost");

   read_seen_c: cover property (cmd_reg == MEM_READ ##[1:20] read_en_out);
   write_seen_c: cover property (cmd_reg == MEM_WRITE);
   row_change_c: cover property (state_reg == ST_PRE && cur_rw);
   refresh_seen_c: cover property (cmd_reg == MEM_REF && init_done_reg);
endmodule : ddrcs_scheduler

// ==== verif/ddrcs_mem_model.sv ====
// Purpose: Behavioural DDR device on the far side of the scheduler.
// Assumes: One open row; commands sampled on rising edge.
// Notes:   Counts illegal commands only.
`timescale 1ns/100ps
module ddrcs_mem_model
   import ddrcs_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic [1:0]  cs_n_in,
   input  wire logic [2:0]  cmd_in,
   input  wire logic [14:0] addr_in,
   output logic [7:0]       viol_out
);
   logic open_reg = 1'b0;
   initial viol_out = 8'h00;
   always @(posedge mclk_in) begin
      if (cs_n_in != 2'h3) begin
         if (cmd_in == MEM_ACT && open_reg) viol_out <= viol_out + 8'h01;
         // access needs open row, no auto close
         if ((cmd_in == MEM_READ || cmd_in == MEM_WRITE)
             && (!open_reg || addr_in[10])) viol_out <= viol_out + 8'h01;
         if (cmd_in == MEM_REF && open_reg) viol_out <= viol_out + 8'h01;
         if (cmd_in == MEM_ACT) open_reg <= 1'b1;
         if (cmd_in == MEM_PRE) open_reg <= 1'b0;
      end
   end
endmodule : ddrcs_mem_model

// ==== verif/ddrcs_scheduler_tb.sv ====
// Purpose: Self-checking bench for the DDR command scheduler.
// Assumes: BL8, CAS 2.5, unbuffered, short init and refresh counts.
// Notes:   Phase one without timebase refresh, phase two with it.
`timescale 1ns/100ps
module ddrcs_scheduler_tb;
   import ddrcs_pkg::*;
   logic                mclk_in = 1'b0;
   logic                reset_in = 1'b1;
   logic                user_valid_in = 1'b0;
   logic                refresh_clk_in = 1'b0;
   logic                ref_run = 1'b0;
   logic [WORD_W-1:0]   user_cmd_addr_word_in = '0;
   logic                user_ready_out, cke_out, ras_n_out, cas_n_out;
   logic                we_n_out, read_en_out, write_en_out, init_done_out;
   logic [1:0]          cs_n_out, ba_out;
   logic [MAX_ROW_W-1:0] addr_out;
   logic [7:0]          viol, rsr = '0, wsr = '0;
   logic [12:0]         row_open;
   logic [2:0]          cmd;
   logic [WORD_W-1:0]   words[$], expq[$], e;
   int seed = 97308, n_mismatch = 0, checks = 0, n_pre = 0, n_act = 0;
   int n_ref = 0;
   ddrcs_scheduler #(.INIT_CYCLES(60), .REFI_COUNT(4)) u_dut (
      .mclk_in               (mclk_in),
      .reset_in              (reset_in),
      .user_cmd_addr_word_in (user_cmd_addr_word_in),
      .user_valid_in         (user_valid_in),
      .user_ready_out        (user_ready_out),
      .refresh_clk_in        (refresh_clk_in),
      .cke_out               (cke_out),
      .cs_n_out              (cs_n_out),
      .ras_n_out             (ras_n_out),
      .cas_n_out             (cas_n_out),
      .we_n_out              (we_n_out),
      .ba_out                (ba_out),
      .addr_out              (addr_out),
      .read_en_out           (read_en_out),
      .write_en_out          (write_en_out),
      .init_done_out         (init_done_out)
   );
   ddrcs_mem_model u_mem (.mclk_in(mclk_in), .cs_n_in(cs_n_out),
      .cmd_in(cmd), .addr_in(addr_out), .viol_out(viol));
   assign cmd = {ras_n_out, cas_n_out, we_n_out};
   always #12.5 mclk_in = ~mclk_in;
   always #100 refresh_clk_in = ref_run ? ~refresh_clk_in : 1'b0;
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   function automatic logic [35:0] mk(input logic [2:0] code);
      logic [12:0] row;
      row = ($random(seed) & 1) ? 13'h0A5 : 13'h1F3;
      return {1'($random(seed)), code, 6'h00, 1'($random(seed)),
              2'($random(seed)), row, 10'($random(seed))};
   endfunction : mk
   function automatic int exp_cnt(input bit act);
      logic [15:0] cur;
      bit open;
      int np, na;
      open = 0; np = 1; na = 0; cur = '0;
      foreach (words[i]) begin
         case (words[i][34:32])
            UCMD_REF: begin np += open; open = 0; end
            UCMD_PRE: begin np++; open = 0; end
            default: begin
               if (open && cur !== words[i][25:10]) np++;
               if (!open || cur !== words[i][25:10]) na++;
               open = 1;
               cur = words[i][25:10];
            end
         endcase
      end
      return act ? na : np;
   endfunction : exp_cnt
   task automatic push(input logic [35:0] w);
      user_valid_in = 1'b1;
      user_cmd_addr_word_in = w;
      if (w[34]) expq.push_back(w);
      do @(posedge mclk_in); while (user_ready_out !== 1'b1);
      #2;
   endtask : push
   task automatic drain;
      for (int k = 0; k < 3000 && expq.size() != 0; k++) @(posedge mclk_in);
      repeat (40) @(posedge mclk_in);
      chk(36'(expq.size()), 36'h0);
      #2;
   endtask : drain
   always @(posedge mclk_in) if (!reset_in) begin
      rsr <= {rsr[6:0], cs_n_out != 2'h3 && cmd == MEM_READ};
      wsr <= {wsr[6:0], cs_n_out != 2'h3 && cmd == MEM_WRITE};
      chk({read_en_out, write_en_out}, {|rsr[5:2], |wsr[3:0]});
      if (cs_n_out != 2'h3) case (cmd)
         MEM_ACT: begin n_act++; row_open <= addr_out[12:0]; end
         MEM_PRE: n_pre++;
         MEM_REF: begin
            n_ref++;
            chk({read_en_out, write_en_out}, 2'h0);
         end
         MEM_MRS: chk(addr_out[6:0], {CAS25_CODE, 1'b0, BL8_CODE});
         MEM_READ, MEM_WRITE: begin
            e = expq.size() ? expq.pop_front() : '1;
            chk({cs_n_out, ba_out, row_open, addr_out[10:0], cmd},
                {~(2'h1 << e[25]), e[24:23], e[22:10], 1'b0, e[9:0],
                 e[34:32] == UCMD_READ ? MEM_READ : MEM_WRITE});
         end
         default: ;
      endcase
   end
   initial begin
      repeat (16) @(posedge mclk_in);
      chk({cke_out, init_done_out, user_ready_out}, 3'h1);
      #2 reset_in = 1'b0;
      for (int i = 0; i < 24; i++)
         words.push_back(mk(i == 5 ? UCMD_REF : i == 9 ? UCMD_PRE :
            ($random(seed) & 1) ? UCMD_READ : UCMD_WRITE));
      words.push_back(words[23] ^ 36'h800000000);
      foreach (words[i]) begin
         if (i == 16) chk(user_ready_out, 1'b0);
         push(words[i]);
      end
      user_valid_in = 1'b0;
      drain();
      chk(36'(n_pre), 36'(exp_cnt(0)));
      chk(36'(n_act), 36'(exp_cnt(1)));
      chk(36'(n_ref), 36'h1);
      chk({cke_out, init_done_out}, 2'h3);
      ref_run = 1'b1;
      repeat (20) push(mk(($random(seed) & 1) ? UCMD_READ : UCMD_WRITE));
      user_valid_in = 1'b0;
      drain();
      repeat (100) @(posedge mclk_in);
      chk(36'(n_ref > 3), 36'h1);
      chk(viol, 8'h00);
      tally_and_finish();
   end
   initial begin
      #500us;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : ddrcs_scheduler_tb
